//--- rtl/pllovr_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts of the PLL override and tuning block.
// Assumes: Byte-wide registers behind the register port, 100 MHz register clock.
// Notes: Definitions only.
`ifndef PLLOVR_CONSTS_SVH
`define PLLOVR_CONSTS_SVH

`define PLLOVR_ADDR_OVERRIDE 8'h58
`define PLLOVR_ADDR_TRIM 8'h59
`define PLLOVR_ADDR_PROG_RESET 8'h5c
`define PLLOVR_ADDR_TUNE_CTRL 8'h5d
`define PLLOVR_ADDR_TUNE_STATUS 8'h5e

`define PLLOVR_OVR_EN_BIT 7
`define PLLOVR_OVR_D_MODE_HI 5
`define PLLOVR_OVR_D_MODE_LO 4
`define PLLOVR_OVR_C_MODE_HI 3
`define PLLOVR_OVR_C_MODE_LO 2
`define PLLOVR_OVR_SE_BIT 1
`define PLLOVR_OVR_PLL_EN_BIT 0
`define PLLOVR_OVR_MASK 8'hbf

`define PLLOVR_TRIM_HI 6
`define PLLOVR_PROG_RESET_BIT 0
`define PLLOVR_CTRL_STL_HI 6
`define PLLOVR_CTRL_STL_LO 4
`define PLLOVR_CTRL_EN_BIT 0
`define PLLOVR_CTRL_MASK 8'h71
`define PLLOVR_DONE_BIT 0

`define PLLOVR_RST_OVERRIDE 8'h00
`define PLLOVR_RST_TRIM 7'h00
`define PLLOVR_RST_PROG_RESET 1'b0
`define PLLOVR_RST_TUNE_CTRL 8'h40
`define PLLOVR_RST_DONE 1'b0

`define PLLOVR_CLK_PERIOD_NS 10
`define PLLOVR_SETTLE_UNIT_NS 100
`define PLLOVR_SETTLE_UNIT_CYC ((`PLLOVR_SETTLE_UNIT_NS + `PLLOVR_CLK_PERIOD_NS - 1) / `PLLOVR_CLK_PERIOD_NS)

`endif

//--- rtl/pllovr_pkg.sv
// Purpose: Types shared by the PLL override and tuning block.
// Assumes: Nothing beyond the constants header.
// Notes: Tuning states are Gray coded along idle, settle, decide, finish.
package pllovr_pkg;

  typedef enum logic [1:0] {
    PLLOVR_IDLE = 2'h0,
    PLLOVR_SETTLE = 2'h1,
    PLLOVR_DECIDE = 2'h3,
    PLLOVR_FINISH = 2'h2
  } pllovr_state_e;

  typedef logic [1:0] pllovr_mode_t;

endpackage

//--- rtl/pllovr_top.sv
// Purpose: Pin-versus-register PLL override, reference output dividers and oscillator tuning engine.
// Assumes: Register port strobes, pins and the frequency comparator are synchronous to i_mclk.
// Notes: The PLL reference arrives as a sampled level; divided outputs are built from its edges.
`timescale 1ns/1ps
`default_nettype none
`include "pllovr_consts.svh"

// Overview of operation
// R01: Override bit selects register fields over configuration pins for PLL control.
// R02: D output mode under override: off, or reference divided by 1, 2, 4.
// R03: D output never clocks unless C output is clocking.
// R04: C output mode under override: off, or reference divided by 1, 2, 4.
// R05: Under override, bit 1 selects the single-ended reference input.
// R06: Under override, bit 0 enables the PLL.
// R07: Seven-bit trim held, written by tuning, readable afterwards.
// R08: Host leaves trim register alone while tuning runs.
// R09: Host sets program reset before PLL changes, clears it after.
// R10: Tuning starts when program reset is written back to zero, if enabled.
// R11: Tuning steps trim to centre the oscillator on its target.
// R12: After each trim change wait a settle time growing with the field.
// R13: Host changes tuning control only while program reset is set.
// R14: Host writes reserved bits with their reset value.
// R15: Read-only completion flag; set when tuning ends or is skipped.
// R16: Setting program reset with tuning enabled clears the completion flag; the code leaves it set if that write lands in the FINISH cycle.
module pllovr_top #(
  parameter int TRIM_W = 7,
  parameter int SETTLE_UNIT_CYC = `PLLOVR_SETTLE_UNIT_CYC,
  parameter int CNT_W = 16
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_pll_enable_pin,
  input wire logic i_single_ended_ref_pin,
  input wire logic i_clock_config_pin_0,
  input wire logic i_clock_config_pin_1,
  input wire logic i_pll_ref,
  input wire logic i_osc_above_target,
  output logic [7:0] o_reg_rdata,
  output logic o_pll_enable,
  output logic o_single_ended_ref_select,
  output logic o_reference_output_c,
  output logic o_reference_output_d,
  output logic [TRIM_W-1:0] o_oscillator_frequency_trim,
  output logic o_pll_program_reset,
  output logic o_tuning_busy
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  initial begin
    if (TRIM_W != 7) begin
      $error("pllovr_top: trim width must be 7 to fit its register");
    end
    if (SETTLE_UNIT_CYC < 1 || CNT_W < 4 || (SETTLE_UNIT_CYC * 8) >= (2 ** CNT_W)) begin
      $error("pllovr_top: settle unit does not fit the settle counter");
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0] override_reg;
  logic [7:0] override_next;
  logic prog_reset_reg;
  logic prog_reset_next;
  logic [7:0] tune_ctrl_reg;
  logic [7:0] tune_ctrl_next;
  logic wr_override;
  logic wr_trim;
  logic wr_prog_reset;
  logic wr_tune_ctrl;
  logic start_tune;
  logic skip_tune;
  logic arm_tune;
  logic tune_enable;

  assign wr_override = i_reg_wr && (i_reg_addr == `PLLOVR_ADDR_OVERRIDE);
  assign wr_trim = i_reg_wr && (i_reg_addr == `PLLOVR_ADDR_TRIM);
  assign wr_prog_reset = i_reg_wr && (i_reg_addr == `PLLOVR_ADDR_PROG_RESET);
  assign wr_tune_ctrl = i_reg_wr && (i_reg_addr == `PLLOVR_ADDR_TUNE_CTRL);
  assign tune_enable = tune_ctrl_reg[`PLLOVR_CTRL_EN_BIT];

  // R10: release starts tuning
  // Only a one-to-zero write counts, so rewriting zero does not restart a finished run.
  assign start_tune = wr_prog_reset && prog_reset_reg && !i_reg_wdata[`PLLOVR_PROG_RESET_BIT] && tune_enable;
  // R15: skipped run completes
  assign skip_tune = wr_prog_reset && prog_reset_reg && !i_reg_wdata[`PLLOVR_PROG_RESET_BIT] && !tune_enable;
  // R16: arming clears completion
  assign arm_tune = wr_prog_reset && i_reg_wdata[`PLLOVR_PROG_RESET_BIT] && tune_enable;

  always_comb begin
    override_next = override_reg;
    prog_reset_next = prog_reset_reg;
    tune_ctrl_next = tune_ctrl_reg;
    // Reserved bits are not stored and read back as zero.
    if (wr_override) begin
      override_next = i_reg_wdata & `PLLOVR_OVR_MASK;
    end
    if (wr_prog_reset) begin
      prog_reset_next = i_reg_wdata[`PLLOVR_PROG_RESET_BIT];
    end
    // The control register is accepted at any time; the host is trusted to hold program reset meanwhile.
    if (wr_tune_ctrl) begin
      tune_ctrl_next = i_reg_wdata & `PLLOVR_CTRL_MASK;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      override_reg <= `PLLOVR_RST_OVERRIDE;
      prog_reset_reg <= `PLLOVR_RST_PROG_RESET;
      tune_ctrl_reg <= `PLLOVR_RST_TUNE_CTRL;
    end else begin
      override_reg <= override_next;
      prog_reset_reg <= prog_reset_next;
      tune_ctrl_reg <= tune_ctrl_next;
    end
  end

  // ****************************************************************
  // Pin or register control selection
  // ****************************************************************
  logic ovr_active;
  logic pll_en_sel;
  logic se_sel;
  pllovr_pkg::pllovr_mode_t c_mode;
  pllovr_pkg::pllovr_mode_t d_mode;

  assign ovr_active = override_reg[`PLLOVR_OVR_EN_BIT];

  // R01: source selection
  always_comb begin
    if (ovr_active) begin
      // R06: register PLL enable
      pll_en_sel = override_reg[`PLLOVR_OVR_PLL_EN_BIT];
      // R05: register reference select
      se_sel = override_reg[`PLLOVR_OVR_SE_BIT];
      // R04: register C mode
      c_mode = override_reg[`PLLOVR_OVR_C_MODE_HI:`PLLOVR_OVR_C_MODE_LO];
      // R02: register D mode
      d_mode = override_reg[`PLLOVR_OVR_D_MODE_HI:`PLLOVR_OVR_D_MODE_LO];
    end else begin
      pll_en_sel = i_pll_enable_pin;
      se_sel = i_single_ended_ref_pin;
      c_mode = {i_clock_config_pin_1, i_clock_config_pin_0};
      d_mode = {i_clock_config_pin_1, i_clock_config_pin_0};
    end
  end

  // ****************************************************************
  // Reference output dividers
  // ****************************************************************
  logic ref_q_reg;
  logic ref_q_next;
  logic [1:0] div_cnt_reg;
  logic [1:0] div_cnt_next;
  logic refc_reg;
  logic refc_next;
  logic refd_reg;
  logic refd_next;
  logic pll_en_reg;
  logic se_reg;

  function automatic logic pick_div(input pllovr_pkg::pllovr_mode_t mode, input logic d1, input logic [1:0] cnt);
    logic val;
    val = 1'b0;
    unique case (mode)
      2'h0: val = 1'b0;
      2'h1: val = d1;
      2'h2: val = cnt[0];
      2'h3: val = cnt[1];
    endcase
    return val;
  endfunction

  always_comb begin
    ref_q_next = i_pll_ref;
    div_cnt_next = div_cnt_reg;
    // A two-bit counter clocked by i_mclk, stepped on each reference rising edge, gives the divide-by-2 and divide-by-4 phases.
    if (i_pll_ref && !ref_q_reg) begin
      div_cnt_next = div_cnt_reg + 2'h1;
    end
    // R04: C output divider
    refc_next = pick_div(c_mode, ref_q_reg, div_cnt_reg);
    // R03: D gated by C
    // R02: D output divider
    refd_next = (c_mode != 2'h0) ? pick_div(d_mode, ref_q_reg, div_cnt_reg) : 1'b0;
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ref_q_reg <= 1'b0;
      div_cnt_reg <= 2'h0;
      refc_reg <= 1'b0;
      refd_reg <= 1'b0;
      pll_en_reg <= 1'b0;
      se_reg <= 1'b0;
    end else begin
      ref_q_reg <= ref_q_next;
      div_cnt_reg <= div_cnt_next;
      refc_reg <= refc_next;
      refd_reg <= refd_next;
      pll_en_reg <= pll_en_sel;
      se_reg <= se_sel;
    end
  end

  // ****************************************************************
  // Oscillator tuning engine
  // ****************************************************************
  pllovr_pkg::pllovr_state_e state_reg;
  pllovr_pkg::pllovr_state_e state_next;
  logic [TRIM_W-1:0] trim_reg;
  logic [TRIM_W-1:0] trim_next;
  logic [2:0] bit_idx_reg;
  logic [2:0] bit_idx_next;
  logic [CNT_W-1:0] settle_cnt_reg;
  logic [CNT_W-1:0] settle_cnt_next;
  logic done_reg;
  logic done_next;
  logic [CNT_W-1:0] settle_load;
  logic [2:0] settle_field;

  assign settle_field = tune_ctrl_reg[`PLLOVR_CTRL_STL_HI:`PLLOVR_CTRL_STL_LO];
  // R12: settle grows with field
  // The wait is (field + 1) settle units; the counter reloads with one less than that.
  assign settle_load = CNT_W'((32'(settle_field) + 32'd1) * 32'(SETTLE_UNIT_CYC) - 32'd1);

  always_comb begin
    state_next = state_reg;
    trim_next = trim_reg;
    bit_idx_next = bit_idx_reg;
    settle_cnt_next = settle_cnt_reg;
    done_next = done_reg;
    // R07: host trim write when idle
    // While a run is active the engine owns the trim and host writes are dropped.
    if (wr_trim && (state_reg == pllovr_pkg::PLLOVR_IDLE)) begin
      trim_next = i_reg_wdata[`PLLOVR_TRIM_HI:0];
    end
    // R16: clear on arming or start
    // Enable is written after arming, so a run that follows a skip must also clear the flag at its start.
    if (arm_tune || start_tune) begin
      done_next = 1'b0;
    end
    unique case (state_reg)
      pllovr_pkg::PLLOVR_IDLE: begin
        if (start_tune) begin
          // R11: successive approximation start
          trim_next = {1'b1, {(TRIM_W - 1){1'b0}}};
          bit_idx_next = 3'(TRIM_W - 1);
          settle_cnt_next = settle_load;
          state_next = pllovr_pkg::PLLOVR_SETTLE;
        end
      end
      pllovr_pkg::PLLOVR_SETTLE: begin
        // R12: wait after trim change
        if (settle_cnt_reg == '0) begin
          state_next = pllovr_pkg::PLLOVR_DECIDE;
        end else begin
          settle_cnt_next = settle_cnt_reg - 1'b1;
        end
      end
      pllovr_pkg::PLLOVR_DECIDE: begin
        // R11: keep or drop trial bit
        if (i_osc_above_target) begin
          trim_next[bit_idx_reg] = 1'b0;
        end
        if (bit_idx_reg == 3'h0) begin
          state_next = pllovr_pkg::PLLOVR_FINISH;
        end else begin
          trim_next[bit_idx_reg - 3'h1] = 1'b1;
          bit_idx_next = bit_idx_reg - 3'h1;
          settle_cnt_next = settle_load;
          state_next = pllovr_pkg::PLLOVR_SETTLE;
        end
      end
      pllovr_pkg::PLLOVR_FINISH: begin
        state_next = pllovr_pkg::PLLOVR_IDLE;
      end
    endcase
    // Re-entering program reset abandons a run in progress and keeps the partial trim.
    if (wr_prog_reset && i_reg_wdata[`PLLOVR_PROG_RESET_BIT] && (state_reg != pllovr_pkg::PLLOVR_FINISH)) begin
      state_next = pllovr_pkg::PLLOVR_IDLE;
    end
    // R15: completion set wins
    if ((state_reg == pllovr_pkg::PLLOVR_FINISH) || skip_tune) begin
      done_next = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= pllovr_pkg::PLLOVR_IDLE;
      trim_reg <= `PLLOVR_RST_TRIM;
      bit_idx_reg <= 3'h0;
      settle_cnt_reg <= '0;
      done_reg <= `PLLOVR_RST_DONE;
    end else begin
      state_reg <= state_next;
      trim_reg <= trim_next;
      bit_idx_reg <= bit_idx_next;
      settle_cnt_reg <= settle_cnt_next;
      done_reg <= done_next;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic busy_reg;
  logic busy_next;

  always_comb begin
    rdata_next = rdata_reg;
    busy_next = (state_next != pllovr_pkg::PLLOVR_IDLE);
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        `PLLOVR_ADDR_OVERRIDE: rdata_next = override_reg;
        // R07: trim readback
        `PLLOVR_ADDR_TRIM: rdata_next = {1'b0, trim_reg};
        `PLLOVR_ADDR_PROG_RESET: rdata_next = {7'h00, prog_reset_reg};
        `PLLOVR_ADDR_TUNE_CTRL: rdata_next = tune_ctrl_reg;
        // R15: status readback
        `PLLOVR_ADDR_TUNE_STATUS: rdata_next = {7'h00, done_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_reg <= 8'h00;
      busy_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      busy_reg <= busy_next;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_pll_enable = pll_en_reg;
  assign o_single_ended_ref_select = se_reg;
  assign o_reference_output_c = refc_reg;
  assign o_reference_output_d = refd_reg;
  assign o_oscillator_frequency_trim = trim_reg;
  assign o_pll_program_reset = prog_reset_reg;
  assign o_tuning_busy = busy_reg;

endmodule // pllovr_top

`default_nettype wire

//--- tb/pllovr_checker.sv
// Purpose: Port-level assertions for the PLL override and tuning block.
// Assumes: Register strobes last one cycle; settle unit comes in by parameter.
// Notes: Helper registers mirror override and control contents from the write strobes.
`timescale 1ns/1ps
`default_nettype none
// ****
// Checker
// ****
module pllovr_checker #(
  parameter int TRIM_W = 7,
  parameter int SETTLE_UNIT_CYC = 10
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_pll_enable_pin,
  input wire logic i_single_ended_ref_pin,
  input wire logic i_clock_config_pin_0,
  input wire logic i_clock_config_pin_1,
  input wire logic i_pll_ref,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_pll_enable,
  input wire logic o_single_ended_ref_select,
  input wire logic o_reference_output_c,
  input wire logic o_reference_output_d,
  input wire logic [TRIM_W-1:0] o_oscillator_frequency_trim,
  input wire logic o_pll_program_reset,
  input wire logic o_tuning_busy
);
  logic [7:0] ovr_reg;
  logic [7:0] ctl_reg;
  logic [2:0] stab_reg;
  logic [15:0] run_reg;
  logic ok_reg;
  logic en_exp;
  logic se_exp;
  logic [1:0] cm;
  logic [1:0] dm;
  assign en_exp = ovr_reg[7] ? ovr_reg[0] : i_pll_enable_pin;
  assign se_exp = ovr_reg[7] ? ovr_reg[1] : i_single_ended_ref_pin;
  assign cm = ovr_reg[7] ? ovr_reg[3:2] : {i_clock_config_pin_1, i_clock_config_pin_0};
  assign dm = ovr_reg[7] ? ovr_reg[5:4] : {i_clock_config_pin_1, i_clock_config_pin_0};
  // Mode checks wait for the divider pipeline to refill after any mode change.
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ovr_reg <= 8'h00;
      ctl_reg <= 8'h40;
      stab_reg <= 3'h0;
      run_reg <= 16'h0000;
      ok_reg <= 1'b0;
    end else begin
      ok_reg <= 1'b1;
      ovr_reg <= (i_reg_wr && i_reg_addr == 8'h58) ? (i_reg_wdata & 8'hbf) : ovr_reg;
      ctl_reg <= (i_reg_wr && i_reg_addr == 8'h5d) ? (i_reg_wdata & 8'h71) : ctl_reg;
      stab_reg <= ((i_reg_wr && i_reg_addr == 8'h58) || $changed({i_clock_config_pin_1, i_clock_config_pin_0})) ?
        3'h0 : ((stab_reg == 3'h7) ? stab_reg : stab_reg + 3'h1);
      run_reg <= o_tuning_busy ? run_reg + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  sequence tune_start_s;
    i_reg_wr && i_reg_addr == 8'h5c && !i_reg_wdata[0] && o_pll_program_reset;
  endsequence
  sequence busy_read_s;
    i_reg_rd && i_reg_addr == 8'h5e && o_tuning_busy;
  endsequence
  pll_en_src_a: assert property (ok_reg |-> o_pll_enable == $past(en_exp)) else $error("pll enable source wrong");
  se_sel_src_a: assert property (ok_reg |-> o_single_ended_ref_select == $past(se_exp)) else $error("ref select wrong");
  c_off_a: assert property (stab_reg == 3'h7 && cm == 2'h0 |-> !o_reference_output_c && !o_reference_output_d)
    else $error("outputs clock with c off");
  c_div1_a: assert property (stab_reg == 3'h7 && cm == 2'h1 |-> o_reference_output_c == $past(i_pll_ref, 2))
    else $error("c output not reference");
  d_div1_a: assert property (stab_reg == 3'h7 && cm != 2'h0 && dm == 2'h1 |-> o_reference_output_d == $past(i_pll_ref, 2))
    else $error("d output not reference");
  d_off_a: assert property (stab_reg == 3'h7 && dm == 2'h0 |-> !o_reference_output_d) else $error("d clocks when off");
  tune_start_a: assert property (tune_start_s ##0 ctl_reg[0] |=> o_tuning_busy [*2]) else $error("tuning not started");
  tune_skip_a: assert property (tune_start_s ##0 !ctl_reg[0] |=> !o_tuning_busy [*2]) else $error("skip ran engine");
  run_len_a: assert property ($fell(o_tuning_busy) && !o_pll_program_reset |->
    run_reg == 7 * ((ctl_reg[6:4] + 1) * SETTLE_UNIT_CYC + 1) + 1) else $error("tuning run length wrong");
  busy_read_a: assert property (busy_read_s |=> o_reg_rdata == 8'h00) else $error("done seen during run");
  trim_write_a: assert property (i_reg_wr && i_reg_addr == 8'h59 && !o_tuning_busy |=>
    {1'b0, o_oscillator_frequency_trim} == ($past(i_reg_wdata) & 8'h7f)) else $error("trim write lost");
endmodule // pllovr_checker
bind pllovr_top pllovr_checker #(.TRIM_W(TRIM_W), .SETTLE_UNIT_CYC(SETTLE_UNIT_CYC)) pllovr_checker_inst (
  .i_mclk(i_mclk), .i_rstn(i_rstn), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_pll_enable_pin(i_pll_enable_pin), .i_single_ended_ref_pin(i_single_ended_ref_pin),
  .i_clock_config_pin_0(i_clock_config_pin_0), .i_clock_config_pin_1(i_clock_config_pin_1), .i_pll_ref(i_pll_ref),
  .o_reg_rdata(o_reg_rdata), .o_pll_enable(o_pll_enable), .o_single_ended_ref_select(o_single_ended_ref_select),
  .o_reference_output_c(o_reference_output_c), .o_reference_output_d(o_reference_output_d),
  .o_oscillator_frequency_trim(o_oscillator_frequency_trim), .o_pll_program_reset(o_pll_program_reset),
  .o_tuning_busy(o_tuning_busy));
`default_nettype wire

//--- tb/pllovr_host.sv
// Purpose: Register host model driving the strobe port of the block.
// Assumes: One strobe cycle per access; read data settles one cycle after the strobe.
// Notes: Released address and data lines show the inverse of their last value.
`timescale 1ns/1ps
`default_nettype none
// ****
// Host
// ****
module pllovr_host (
  input wire logic i_mclk,
  input wire logic [7:0] i_reg_rdata,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata
);
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    o_reg_wr <= 1'b1;
    o_reg_addr <= a;
    o_reg_wdata <= d;
    @(posedge i_mclk);
    o_reg_wr <= 1'b0;
    o_reg_addr <= ~a;
    o_reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    o_reg_rd <= 1'b1;
    o_reg_addr <= a;
    @(posedge i_mclk);
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~a;
    #1 d = i_reg_rdata;
  endtask
  task automatic prog(input logic [7:0] ctl, output logic [7:0] st);
    wr(8'h5c, 8'h01);
    rd(8'h5e, st);
    wr(8'h5d, ctl & 8'h71);
    wr(8'h5c, 8'h00);
  endtask
  task automatic wait_done(output logic ok);
    logic [7:0] st;
    ok = 1'b0;
    for (int i = 0; i < 60 && !ok; i++) begin
      rd(8'h5e, st);
      ok = (st === 8'h01);
    end
  endtask
endmodule // pllovr_host
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the PLL override and tuning block.
// Assumes: Settle unit shortened to one cycle; comparator modelled from the trim.
// Notes: Fixed seed; corner targets 0x00 and 0x7f among random ones.
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench
// ****
module tb_top;
  logic i_mclk, i_rstn, wr, rd, en_pin, se_pin, cfg0, cfg1, pll_ref, above;
  logic pll_en, se_sel, ref_c, ref_d, prog_rst, busy, c_q, d_q, cnt_on;
  logic [7:0] addr, wdata, rdata;
  logic [6:0] trim, target;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  int nc = 0;
  int nd = 0;
  logic [15:0] rst_tab [6] = '{16'h5800, 16'h5900, 16'h5c00, 16'h5d40, 16'h5e00, 16'h5a00};
  logic [7:0] div_tab [4] = '{8'h94, 8'ha8, 8'hbc, 8'hb0};
  int cnt_tab [4] = '{40, 20, 10, 0};
  pllovr_top #(.SETTLE_UNIT_CYC(1)) pllovr_top_inst (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_pll_enable_pin(en_pin), .i_single_ended_ref_pin(se_pin),
    .i_clock_config_pin_0(cfg0), .i_clock_config_pin_1(cfg1), .i_pll_ref(pll_ref), .i_osc_above_target(above),
    .o_reg_rdata(rdata), .o_pll_enable(pll_en), .o_single_ended_ref_select(se_sel), .o_reference_output_c(ref_c),
    .o_reference_output_d(ref_d), .o_oscillator_frequency_trim(trim), .o_pll_program_reset(prog_rst),
    .o_tuning_busy(busy));
  pllovr_host pllovr_host_inst (.i_mclk(i_mclk), .i_reg_rdata(rdata), .o_reg_wr(wr), .o_reg_rd(rd),
    .o_reg_addr(addr), .o_reg_wdata(wdata));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic sel_exp(input logic [7:0] v, input logic pin, input int b);
    return v[7] ? v[b] : pin;
  endfunction
  // The oscillator reads above target whenever the trim overshoots the hidden target.
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    pll_ref <= ~pll_ref;
    above <= trim > target;
    c_q <= ref_c;
    d_q <= ref_d;
    if (cnt_on && ref_c && !c_q) nc++;
    if (cnt_on && ref_d && !d_q) nd++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    logic [7:0] v;
    logic [7:0] st;
    logic ok;
    {i_rstn, en_pin, se_pin, cfg0, cfg1, pll_ref, above, cnt_on, target} = '0;
    v = $urandom(32'hb41d9e8e);
    repeat (12) @(posedge i_mclk);
    i_rstn <= 1'b1;
    foreach (rst_tab[i]) begin
      pllovr_host_inst.rd(rst_tab[i][15:8], st);
      chk(st, rst_tab[i][7:0]);
    end
    repeat (8) begin
      v = $urandom;
      @(posedge i_mclk);
      {en_pin, se_pin, cfg1, cfg0} <= v[3:0];
      repeat (3) @(posedge i_mclk);
      #1 chk({6'h0, pll_en, se_sel}, {6'h0, v[3:2]});
    end
    repeat (8) begin
      v = $urandom & 8'hbf;
      pllovr_host_inst.wr(8'h58, v);
      {en_pin, se_pin} <= ~{en_pin, se_pin};
      pllovr_host_inst.rd(8'h58, st);
      chk(st, v);
      chk({6'h0, pll_en, se_sel}, {6'h0, sel_exp(v, en_pin, 0), sel_exp(v, se_pin, 1)});
    end
    foreach (div_tab[i]) begin
      pllovr_host_inst.wr(8'h58, div_tab[i]);
      repeat (8) @(posedge i_mclk);
      nc = 0;
      nd = 0;
      cnt_on <= 1'b1;
      repeat (80) @(posedge i_mclk);
      cnt_on <= 1'b0;
      chk({7'h0, nc >= cnt_tab[i] - 1 && nc <= cnt_tab[i] + 1}, 8'h01);
      chk({7'h0, nd >= cnt_tab[i] - 1 && nd <= cnt_tab[i] + 1}, 8'h01);
    end
    pllovr_host_inst.prog(8'h40, st);
    @(posedge i_mclk);
    #1 chk({6'h0, busy, prog_rst}, 8'h00);
    pllovr_host_inst.rd(8'h5e, st);
    chk(st, 8'h01);
    for (int k = 0; k < 5; k++) begin
      target <= (k == 0) ? 7'h00 : (k == 1) ? 7'h7f : 7'($urandom);
      v = {1'b0, 3'($urandom), 3'h0, 1'b1};
      pllovr_host_inst.prog(v, st);
      chk(st, (k == 0) ? 8'h01 : 8'h00);
      pllovr_host_inst.wait_done(ok);
      chk({7'h0, ok}, 8'h01);
      chk({1'b0, trim}, {1'b0, target});
      pllovr_host_inst.rd(8'h59, st);
      chk(st, {1'b0, target});
    end
    v = $urandom & 8'h7f;
    pllovr_host_inst.wr(8'h59, v);
    pllovr_host_inst.rd(8'h59, st);
    chk(st, v);
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
